// *** core/host_port_map.svh ***
// Named constants for the byte-wide host port: widths, pin vector layout and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define HP_WORD_W      16
`define HP_BYTE_W      8
`define HP_BUF_DEPTH   2
`define HP_SYNC_STAGES 3

// Layout of the synchronised pin vector.
`define HP_PIN_W       22
`define HP_PIN_DATA_LO 0
`define HP_PIN_DATA_HI 15
`define HP_PIN_SEL     16
`define HP_PIN_CMD     17
`define HP_PIN_WR      18
`define HP_PIN_RD      19
`define HP_PIN_EN      20
`define HP_PIN_WIDE    21

// Idle pin levels: strobes and select high, bus pulled up, port disabled.
`define HP_PIN_IDLE    22'h0FFFFF
`define HP_WORD_ZERO   16'h0000
`define HP_BYTE_ZERO   8'h00
`define HP_OE_NONE     16'h0000
`define HP_OE_LOW      16'h00FF
`define HP_OE_ALL      16'hFFFF

`endif

// *** core/host_port_pkg.sv ***
// Types shared by the byte-wide host port and its word buffer.
// Assumes the constant header is on the include path.
`include "host_port_map.svh"

package host_port_pkg;

  typedef logic [`HP_WORD_W-1:0] host_data_t;

  // One word taken from the host, with its command or data marking.
  typedef struct packed {
    logic       isCommand;
    host_data_t data;
  } host_word_s;

endpackage

// *** core/word_buf_if.sv ***
// Carrier between the host port and its two-entry word buffer.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none

interface word_buf_if;
  import host_port_pkg::*;

  logic       inValid;
  logic       inReady;
  host_word_s inWord;
  logic       outValid;
  logic       outReady;
  host_word_s outWord;

  modport store (
    input  inValid,
    input  inWord,
    input  outReady,
    output inReady,
    output outValid,
    output outWord
  );

  modport owner (
    output inValid,
    output inWord,
    output outReady,
    input  inReady,
    input  outValid,
    input  outWord
  );
endinterface

`default_nettype wire

// *** core/word_buffer.sv ***
// Two-entry word buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

// The constant header is pulled in here too, so the file stands alone.
`include "host_port_map.svh"

module word_buffer
  import host_port_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    rst,
  word_buf_if.store    port
);

  host_word_s mem_q [`HP_BUF_DEPTH];
  host_word_s mem_d [`HP_BUF_DEPTH];
  logic       wrPtr_q, wrPtr_d;
  logic       rdPtr_q, rdPtr_d;
  logic [1:0] count_q, count_d;
  logic       push, pop;

  // Full and empty come straight from the count so the source sees stalls at once.
  assign port.inReady  = (count_q != 2'(`HP_BUF_DEPTH));
  assign port.outValid = (count_q != 2'h0);
  assign port.outWord  = mem_q[rdPtr_q];
  assign push          = port.inValid && port.inReady;
  assign pop           = port.outValid && port.outReady;

  // Next pointers, count and storage.
  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = port.inWord;
      wrPtr_d        = ~wrPtr_q;
    end
    if (pop) begin
      rdPtr_d = ~rdPtr_q;
    end
    count_d = count_q + 2'(push) - 2'(pop);
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
      for (int i = 0; i < `HP_BUF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
      mem_q   <= mem_d;
    end
  end

endmodule // word_buffer

`default_nettype wire

// *** core/byte_wide_host_port.sv ***
// Device end of the parallel host port: strobe-driven word and byte transfers.
// Assumes all host pins are asynchronous to sys_clk and that the host holds each
// strobe level for several sys_clk periods, as a slow firmware-driven host does.
`timescale 1ns/1ps
`default_nettype none

// The constant header is pulled in here too, so the file stands alone.
`include "host_port_map.svh"

// Operation
// - Sixteen-bit bus or two-byte words.
// - Command flag picks command/data or status.
// - Ready output plus active-low attention output.
// - Read: select and read strobe low.
// - High byte first, then low byte.
module byte_wide_host_port
  import host_port_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  parallel_port_enable,
  input  wire logic                  wideBusMode,
  input  wire logic [`HP_WORD_W-1:0] host_byte_lines_i,
  output logic      [`HP_WORD_W-1:0] host_byte_lines_o,
  output logic      [`HP_WORD_W-1:0] host_byte_lines_oe,
  input  wire logic                  host_select_n,
  input  wire logic                  host_command_flag,
  input  wire logic                  host_write_strobe_n,
  input  wire logic                  host_read_strobe_n,
  output logic                       host_port_ready,
  output logic                       host_attention_n,
  input  wire logic                  attentionRequest,
  output logic                       rxValid,
  input  wire logic                  rxReady,
  output host_data_t                 rxData,
  output logic                       rxIsCommand,
  input  wire host_data_t            readWord,
  input  wire logic                  readValid,
  output logic                       readTaken,
  input  wire host_data_t            statusWord
);

  logic [`HP_PIN_W-1:0]       pins;
  logic [`HP_PIN_W-1:0]       sync1_q, sync2_q, sync3_q;
  logic [`HP_PIN_W-1:0]       filt_q, filt_d, prev_q;
  logic                       selF, cmdF, wrF, rdF, enF, wideF;
  host_data_t                 dataF;
  logic                       wrRise, rdFall, rdRise, selRise;
  logic                       half_q, half_d;
  logic [`HP_BYTE_W-1:0]      hiByte_q, hiByte_d;
  host_data_t                 rdOut_q, rdOut_d;
  logic [`HP_WORD_W-1:0]      oe_q, oe_d;
  logic                       ready_q, ready_d;
  logic                       attn_n_q, attn_n_d;
  host_data_t                 rdSource;
  word_buf_if                 bif ();

  // Strobe qualified by the port's own select, so a stray strobe is ignored.
  function automatic logic strobeActive(input logic selN, input logic strobeN);
    return !selN && !strobeN;
  endfunction

  // Packs every asynchronous pin into one vector for the synchroniser.
  assign pins = {wideBusMode, parallel_port_enable, host_read_strobe_n, host_write_strobe_n,
                 host_command_flag, host_select_n, host_byte_lines_i};

  // A bit changes only when the second and third stages agree, which filters glitches.
  generate
    for (genvar i = 0; i < `HP_PIN_W; i++) begin : g_filt
      assign filt_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : filt_q[i];
    end
  endgenerate

  assign selF  = filt_q[`HP_PIN_SEL];
  assign cmdF  = filt_q[`HP_PIN_CMD];
  assign wrF   = filt_q[`HP_PIN_WR];
  assign rdF   = filt_q[`HP_PIN_RD];
  assign enF   = filt_q[`HP_PIN_EN];
  assign wideF = filt_q[`HP_PIN_WIDE];
  assign dataF = filt_q[`HP_PIN_DATA_HI:`HP_PIN_DATA_LO];

  assign rdFall  = enF && strobeActive(selF, rdF) && prev_q[`HP_PIN_RD];
  assign rdRise  = enF && !selF && rdF && !prev_q[`HP_PIN_RD];
  assign wrRise  = enF && !selF && wrF && !prev_q[`HP_PIN_WR];
  assign selRise = selF && !prev_q[`HP_PIN_SEL];

  assign rdSource = cmdF ? statusWord : readWord;

  // Word assembly and push into the buffer.
  always_comb begin
    half_d      = half_q;
    hiByte_d    = hiByte_q;
    bif.inValid = 1'b0;
    bif.inWord  = '{isCommand: cmdF, data: dataF};
    readTaken   = 1'b0;
    if (selRise || !enF) begin
      half_d = 1'b0;
    end else if (wrRise) begin
      if (wideF) begin
        bif.inValid = 1'b1;
      end else if (!half_q) begin
        hiByte_d = dataF[`HP_BYTE_W-1:0];
        half_d   = 1'b1;
      end else begin
        bif.inValid = 1'b1;
        bif.inWord  = '{isCommand: cmdF, data: {hiByte_q, dataF[`HP_BYTE_W-1:0]}};
        half_d      = 1'b0;
      end
    end else if (rdRise) begin
      // Only a data read that completes the word consumes the word.
      readTaken = !cmdF && readValid && (wideF || half_q);
      half_d    = wideF ? 1'b0 : ~half_q;
    end
  end

  always_comb begin
    rdOut_d = rdOut_q;
    if (rdFall) begin
      if (wideF) begin
        rdOut_d = rdSource;
      end else if (!half_q) begin
        rdOut_d = {`HP_BYTE_ZERO, rdSource[`HP_WORD_W-1:`HP_BYTE_W]};
      end else begin
        rdOut_d = {`HP_BYTE_ZERO, rdSource[`HP_BYTE_W-1:0]};
      end
    end
    if (enF && strobeActive(selF, rdF)) begin
      oe_d = wideF ? `HP_OE_ALL : `HP_OE_LOW;
    end else begin
      oe_d = `HP_OE_NONE;
    end
  end

  // attention output.
  // Ready also waits on buffer room, so a stalled receiver holds the host off.
  always_comb begin
    ready_d  = enF && bif.inReady && !half_q && selF;
    attn_n_d = !(enF && attentionRequest);
  end

  // Registers only; the first stage feeds nothing but the second.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q  <= `HP_PIN_IDLE;
      sync2_q  <= `HP_PIN_IDLE;
      sync3_q  <= `HP_PIN_IDLE;
      filt_q   <= `HP_PIN_IDLE;
      prev_q   <= `HP_PIN_IDLE;
      half_q   <= 1'b0;
      hiByte_q <= `HP_BYTE_ZERO;
      rdOut_q  <= `HP_WORD_ZERO;
      oe_q     <= `HP_OE_NONE;
      ready_q  <= 1'b0;
      attn_n_q <= 1'b1;
    end else begin
      sync1_q  <= pins;
      sync2_q  <= sync1_q;
      sync3_q  <= sync2_q;
      filt_q   <= filt_d;
      prev_q   <= filt_q;
      half_q   <= half_d;
      hiByte_q <= hiByte_d;
      rdOut_q  <= rdOut_d;
      oe_q     <= oe_d;
      ready_q  <= ready_d;
      attn_n_q <= attn_n_d;
    end
  end

  // Received words queue here so a stalled receiver loses nothing.
  word_buffer u_buf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (bif.store)
  );

  assign bif.outReady       = rxReady;
  assign rxValid            = bif.outValid;
  assign rxData             = bif.outWord.data;
  assign rxIsCommand        = bif.outWord.isCommand;
  assign host_byte_lines_o  = rdOut_q;
  assign host_byte_lines_oe = oe_q;
  assign host_port_ready    = ready_q;
  assign host_attention_n   = attn_n_q;

endmodule // byte_wide_host_port

`default_nettype wire

// *** testbench/byte_wide_host_port_props.sv ***
// Checker for the host port's pin and stream outputs.
// Assumes a bind to the port's top module; it sees ports only.
`timescale 1ns/1ps
`default_nettype none

module byte_wide_host_port_props
  import host_port_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       parallel_port_enable,
  input wire host_data_t host_byte_lines_oe,
  input wire logic       host_select_n,
  input wire logic       host_read_strobe_n,
  input wire logic       host_port_ready,
  input wire logic       host_attention_n,
  input wire logic       attentionRequest,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire host_data_t rxData,
  input wire logic       readTaken,
  input wire logic       readValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Eight quiet cycles cover the pin filter, so outputs are judged once settled.
  sequence readIdle;
    (host_read_strobe_n && host_select_n)[*8];
  endsequence
  sequence selectHeld;
    (!host_select_n)[*8];
  endsequence
  sequence portOff;
    (!parallel_port_enable)[*8];
  endsequence
  sequence attnAsked;
    parallel_port_enable[*8] ##0 attentionRequest;
  endsequence

  AST_RESET_QUIET: assert property ($fell(rst) |-> host_byte_lines_oe == 16'h0000
    && !rxValid && !host_port_ready) else $error("Outputs active after reset.");
  AST_OE_IDLE: assert property (readIdle |-> host_byte_lines_oe == 16'h0000)
    else $error("Bus driven without a read.");
  AST_OE_SHAPE: assert property (host_byte_lines_oe inside {16'h0000, 16'h00FF, 16'hFFFF})
    else $error("Bus enable pattern is neither byte nor word.");
  AST_OFF_QUIET: assert property (portOff |-> !host_port_ready && host_byte_lines_oe == 16'h0000)
    else $error("Disabled port still active.");
  AST_ATTN_ON: assert property (attnAsked |=> !host_attention_n)
    else $error("Attention not raised.");
  AST_SEL_NOT_READY: assert property (selectHeld |-> !host_port_ready)
    else $error("Ready high inside a select period.");
  AST_TAKEN_PULSE: assert property (readTaken |-> readValid ##1 !readTaken)
    else $error("Read taken is not a single valid pulse.");
  AST_RX_HOLD: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
    else $error("Stalled word changed or vanished.");
endmodule // byte_wide_host_port_props

bind byte_wide_host_port byte_wide_host_port_props u_props (.*);
`default_nettype wire

// *** testbench/host_model.sv ***
// Slow firmware-style host driving the port's strobes and byte lines.
// Assumes the bench calls its tasks at falling clock edges.
`timescale 1ns/1ps
`default_nettype none

module host_model
  import host_port_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       ready,
  input  wire logic       wide,
  input  wire host_data_t devData,
  input  wire host_data_t devOe,
  output host_data_t      bus,
  output logic            selN,
  output logic            cmd,
  output logic            wrN,
  output logic            rdN
);
  host_data_t drvData;
  logic       drvOn;

  // pulled-up lines.
  // Released lines float high, so a stale byte never passes for data.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      bus[i] = devOe[i] ? devData[i] : (drvOn ? drvData[i] : 1'b1);
    end
  end

  // Idle host: controls high, outputs off.
  initial begin
    {rdN, wrN, cmd, selN} = 4'hF;
    drvOn = 1'b0;
    drvData = 16'hFFFF;
  end

  task automatic step(input logic [3:0] nib);
    {rdN, wrN, cmd, selN} = nib;
    repeat (10) @(negedge sys_clk);
  endtask

  task automatic wait_ready(output bit ok);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    ok = (ready === 1'b1);
  endtask

  task automatic write_word(input logic c, input host_data_t w, output bit ok);
    wait_ready(ok);
    if (ok) begin
      drvOn = 1'b1;
      for (int k = 0; k < (wide ? 1 : 2); k++) begin
        drvData = wide ? w : {8'hFF, (k == 0) ? w[15:8] : w[7:0]};
        repeat (2) @(negedge sys_clk);
        step({2'b10, c, 1'b0});
        step({2'b11, c, 1'b0});
      end
      step(4'hF);
      drvOn = 1'b0;
    end
  endtask

  task automatic read_word(input logic c, output host_data_t r, output bit ok);
    wait_ready(ok);
    r = 16'h0000;
    if (ok) begin
      for (int k = 0; k < (wide ? 1 : 2); k++) begin
        step({2'b01, c, 1'b0});
        r = wide ? bus : {r[7:0], bus[7:0]};
        step({2'b11, c, 1'b0});
      end
      step(4'hF);
    end
  endtask
endmodule // host_model
`default_nettype wire

// *** testbench/byte_wide_host_port_tb_top.sv ***
// Self-checking bench for the host port, driven through the host model.
// Assumes the package, buffer and port design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module byte_wide_host_port_tb_top;
  import host_port_pkg::*;
  logic sys_clk, rst, parallel_port_enable, wideBusMode, attentionRequest, rxReady;
  logic host_select_n, host_command_flag, host_write_strobe_n, host_read_strobe_n;
  logic host_port_ready, host_attention_n, rxValid, rxIsCommand, readTaken, readValid;
  host_data_t host_byte_lines_i, host_byte_lines_o, host_byte_lines_oe, rxData;
  host_data_t readWord, statusWord, got;
  int failCount, testsRun, takenCnt;
  bit ok;

  byte_wide_host_port u_dut (.sys_clk, .rst, .parallel_port_enable, .wideBusMode,
    .host_byte_lines_i, .host_byte_lines_o, .host_byte_lines_oe, .host_select_n,
    .host_command_flag, .host_write_strobe_n, .host_read_strobe_n, .host_port_ready,
    .host_attention_n, .attentionRequest, .rxValid, .rxReady, .rxData, .rxIsCommand,
    .readWord, .readValid, .readTaken, .statusWord);
  host_model u_host (.sys_clk, .ready(host_port_ready), .wide(wideBusMode),
    .devData(host_byte_lines_o), .devOe(host_byte_lines_oe), .bus(host_byte_lines_i),
    .selN(host_select_n), .cmd(host_command_flag), .wrN(host_write_strobe_n),
    .rdN(host_read_strobe_n));

  // Clock at 50 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Count finished data reads.
  always @(posedge sys_clk) if (readTaken === 1'b1) takenCnt++;

  task automatic chk_w(input host_data_t g, input host_data_t e);
    testsRun++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_w({15'h0000, g}, {15'h0000, e});
  endtask

  // Take one buffered word; ready is pulsed for exactly one edge.
  task automatic pop(input logic c, input host_data_t d);
    int n;
    n = 0;
    while (rxValid !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk_b(rxIsCommand, c);
    chk_w(rxData, d);
    rxReady = 1'b1;
    @(negedge sys_clk);
    rxReady = 1'b0;
  endtask

  // Two words fill the stalled buffer; a third must find ready low.
  task automatic test_byte_write();
    u_host.write_word(1'b0, 16'hA1B2, ok);
    u_host.write_word(1'b1, 16'h00C3, ok);
    u_host.write_word(1'b0, 16'h7E7E, ok);
    chk_b(ok, 1'b0);
    pop(1'b0, 16'hA1B2);
    pop(1'b1, 16'h00C3);
    chk_b(rxValid, 1'b0);
  endtask

  // A data read consumes the word; a status read does not.
  task automatic test_byte_read();
    readWord = 16'h5AC3;
    statusWord = 16'h9E01;
    readValid = 1'b1;
    u_host.read_word(1'b0, got, ok);
    chk_w(got, 16'h5AC3);
    chk_b(takenCnt == 1, 1'b1);
    u_host.read_word(1'b1, got, ok);
    chk_w(got, 16'h9E01);
    chk_b(takenCnt == 1, 1'b1);
  endtask

  // Whole words in one transfer on the wide bus.
  task automatic test_wide();
    wideBusMode = 1'b1;
    repeat (10) @(negedge sys_clk);
    u_host.write_word(1'b1, 16'hBEEF, ok);
    pop(1'b1, 16'hBEEF);
    u_host.read_word(1'b0, got, ok);
    chk_w(got, 16'h5AC3);
    chk_b(takenCnt == 2, 1'b1);
    wideBusMode = 1'b0;
  endtask

  // A disabled port ignores the host and holds attention off.
  task automatic test_disable();
    parallel_port_enable = 1'b0;
    attentionRequest = 1'b1;
    repeat (12) @(negedge sys_clk);
    chk_b(host_attention_n, 1'b1);
    u_host.write_word(1'b0, 16'h1234, ok);
    chk_b(ok, 1'b0);
    parallel_port_enable = 1'b1;
    repeat (12) @(negedge sys_clk);
    chk_b(host_attention_n, 1'b0);
    attentionRequest = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_b(host_attention_n, 1'b1);
  endtask

  task automatic complete_run();
    $display("mismatches=%0d comparisons=%0d", failCount, testsRun);
    if (failCount == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence; reset held ten cycles.
  initial begin
    {rst, parallel_port_enable, wideBusMode, attentionRequest, rxReady, readValid} = 6'h30;
    readWord = 16'h0000;
    statusWord = 16'h0000;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    test_byte_write();
    test_byte_read();
    test_wide();
    test_disable();
    complete_run();
  end

  // Watchdog, well past the fewer than a thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    complete_run();
  end
endmodule // byte_wide_host_port_tb_top
`default_nettype wire
